/* File: ggrb_register_bank.sv */
// module: host-visible register bank of the charge gauge
// Summary of operation
// - temperature and gauge byte at 02h, temperature high nibble, gauge low nibble
// - gauge nibble is available charge over full reference in sixteenths
// - available charge at 03h/17h counts up on charge, down on discharge
// - pack-type tag at 04h is host read/write and steers nothing
// - learned full capacity at 05h is read/write and learned from full-to-empty discharge
// - charge-rate flag sets on charge start, clears below 2 counts per second
// - charge-rate flag selects fast or trickle efficiency factors
// - overload flag follows sensed voltage below threshold chosen by pin 4
// - pull-down map at 07h, bit n-1 for pin n, top bits zero
// - pull-up map at 08h, bit n-1 for pin n, top bits zero
// - override enable drives segments 5..1 from override bits 5..1
// - override enable clears on host write of zero or on reset
// - offset register initialises from pin 6 to 0, 46 or 23
// - self-discharge register initialises from pin 3
// - filter threshold at 0dh is read/write, sets both valid thresholds
// - load compensation discharges counter at constant rate below charge threshold
// - charge compensation at 0fh initialises from pin 5, host writable
// - pin 5 high: minus 5 percent per band, trickle 15 percent lower
// - zero to soft-reset register then zero to full capacity resets device
// - reset loads full capacity, clears valid-discharge flag, override enable, counter, load comp, sets replaced
`timescale 1ns/1ps
`default_nettype none
module ggrb_register_bank (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  // serial decoder request
  input  wire logic       reqWr,
  input  wire logic       reqRd,
  input  wire logic [6:0] reqAddr,
  input  wire logic [7:0] reqData,
  output logic [7:0]      rdData,
  output logic            rdValid,
  // measurement pulses and levels from the analog front end
  input  wire logic       chargeTick,
  input  wire logic       dischargeTick,
  input  wire logic       selfDischargeTick,
  input  wire logic       loadCompTick,
  input  wire logic       belowChargeThresh,
  input  wire logic       belowOverloadThresh,
  input  wire logic       atEmpty,
  input  wire logic [3:0] temperatureCode,
  // program pin straps and programmed capacity
  input  wire logic [5:0] pinPulldown,
  input  wire logic [5:0] pinPullup,
  input  wire logic [7:0] programmedFullCapacity,
  // display and status
  input  wire logic [4:0] displaySegments,
  output logic [4:0]      segmentOutput,
  output logic [7:0]      chargeEfficiency,
  output logic [7:0]      filterThreshold,
  output logic [7:0]      offsetCorrection,
  output logic [7:0]      selfDischargeRate,
  output logic            batteryReplacedFlag,
  output logic            validDischargeFlag
);
  ggrb_host_if hostBus ();

  typedef struct packed {
    logic [1:0]  pinPhase;
    logic [15:0] availCharge;
    logic [7:0]  packTypeTag;
    logic [7:0]  learnedFull;
    logic        chargeRateFlag;
    logic        overloadFlag;
    logic [5:0]  pulldownMap;
    logic [5:0]  pullupMap;
    logic        overrideEnable;
    logic [4:0]  overrideBits;
    logic        overrideMsb;
    logic [7:0]  offsetCorr;
    logic [7:0]  selfDis;
    logic [7:0]  filterThr;
    logic [7:0]  loadComp;
    logic [7:0]  chargeComp;
    logic        softResetArmed;
    logic        replaced;
    logic        validDis;
    logic [15:0] discharged;
    logic [26:0] rateTimer;
    logic [7:0]  rateCount;
    logic [7:0]  rdData;
    logic        rdValid;
    logic [4:0]  segOut;
    logic [7:0]  effOut;
  } ggrb_state_t;
  ggrb_state_t st_q, st_d;

  logic [3:0]  gaugeNibble;
  logic [15:0] fullRef;

  // a window of one second is long, so it is a parameter for simulation
  localparam logic [26:0] RATE_WINDOW = 27'(ggrb_pkg::RATE_WINDOW_CYC);

  function automatic logic [7:0] offsetFromPin(input logic dn, input logic up);
    if (up) begin
      offsetFromPin = ggrb_pkg::OFFSET_150UV;
    end else if (dn) begin
      offsetFromPin = ggrb_pkg::OFFSET_75UV;
    end else begin
      offsetFromPin = ggrb_pkg::OFFSET_NONE;
    end
  endfunction : offsetFromPin

  // strap coding for self-discharge and charge comp; values beyond the three levels are plain defaults
  function automatic logic [7:0] strapLevel(input logic dn, input logic up,
                                             input logic [7:0] lo, input logic [7:0] mid, input logic [7:0] hi);
    if (up) begin
      strapLevel = hi;
    end else if (dn) begin
      strapLevel = lo;
    end else begin
      strapLevel = mid;
    end
  endfunction : strapLevel

  function automatic logic [7:0] satSub(input logic [7:0] a, input logic [7:0] b);
    satSub = (a > b) ? 8'(a - b) : ggrb_pkg::ZERO_BYTE;
  endfunction : satSub

  ggrb_port_front u_front (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .reqWr   (reqWr),
    .reqRd   (reqRd),
    .reqAddr (reqAddr),
    .reqData (reqData),
    .bus     (hostBus.port)
  );

  assign fullRef = {st_q.learnedFull, ggrb_pkg::ZERO_BYTE};

  ggrb_gauge_calc u_gauge (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .clkEn       (clkEn),
    .availCharge (st_q.availCharge),
    .fullRef     (fullRef),
    .gaugeNibble (gaugeNibble)
  );

  logic       softReset;
  logic [7:0] bandsAbove;
  logic [7:0] eff;
  logic [7:0] rdMux;

  always_comb begin
    st_d = st_q;
    softReset = 1'b0;
    bandsAbove = ggrb_pkg::ZERO_BYTE;
    eff = st_q.chargeComp;
    rdMux = ggrb_pkg::ZERO_BYTE;
    st_d.rdValid = 1'b0;

    // straps are taken on the first enabled cycles after reset release
    if (st_q.pinPhase == 2'h1) begin
      st_d.pulldownMap = pinPulldown;
      st_d.pullupMap   = pinPullup;
      st_d.offsetCorr  = offsetFromPin(pinPulldown[5], pinPullup[5]);
      st_d.selfDis     = strapLevel(pinPulldown[2], pinPullup[2], 8'hfe, 8'hfd, 8'hfc);
      st_d.chargeComp  = strapLevel(pinPulldown[4], pinPullup[4], 8'h64, 8'h5f, 8'h5a);
      st_d.pinPhase    = 2'h2;
    end else if (st_q.pinPhase == 2'h0) begin
      st_d.pinPhase = 2'h1;
    end

    // charge counting
    if (chargeTick && st_q.availCharge != 16'hffff) begin
      st_d.availCharge = 16'(st_q.availCharge + 16'h0001);
      if (!st_q.chargeRateFlag && st_q.rateCount == ggrb_pkg::ZERO_BYTE) begin
        st_d.chargeRateFlag = 1'b1;
      end
      st_d.validDis = 1'b0;
      if (st_d.availCharge >= fullRef) begin
        st_d.replaced = 1'b0;
      end
    end else if ((dischargeTick || selfDischargeTick ||
                 (loadCompTick && belowChargeThresh && st_q.loadComp != ggrb_pkg::ZERO_BYTE))
                 && st_q.availCharge != ggrb_pkg::ZERO_WORD) begin
      st_d.availCharge = 16'(st_q.availCharge - 16'h0001);
      st_d.discharged  = 16'(st_q.discharged + 16'h0001);
      if (st_q.availCharge >= fullRef) begin
        st_d.validDis   = 1'b1;
        st_d.discharged = 16'h0001;
      end
    end

    // learn full capacity on a qualified full-to-empty discharge
    if (atEmpty && st_q.validDis) begin
      st_d.learnedFull = st_q.discharged[15:8];
      st_d.validDis    = 1'b0;
    end

    // charge rate: count ticks per one-second window
    // a tick on the window edge counts into the next window and wins over the clear
    if (st_q.rateTimer == RATE_WINDOW - 27'h1) begin
      st_d.rateTimer = '0;
      st_d.rateCount = chargeTick ? 8'h01 : ggrb_pkg::ZERO_BYTE;
      if (st_q.rateCount < ggrb_pkg::FAST_RATE_MIN && !chargeTick) begin
        st_d.chargeRateFlag = 1'b0;
      end
    end else begin
      st_d.rateTimer = 27'(st_q.rateTimer + 27'h1);
      if (chargeTick) begin
        st_d.rateCount = 8'(st_q.rateCount + 8'h01);
      end
    end

    st_d.overloadFlag = belowOverloadThresh;

    // efficiency: fast above 30C bands, trickle further reduced
    if (pinPullup[4] && temperatureCode > ggrb_pkg::TEMP_BAND_30C) begin
      bandsAbove = 8'({4'h0, temperatureCode - ggrb_pkg::TEMP_BAND_30C} * ggrb_pkg::TEMP_BAND_STEP);
    end
    eff = satSub(st_q.chargeComp, bandsAbove);
    if (!st_q.chargeRateFlag && pinPullup[4]) begin
      eff = satSub(eff, ggrb_pkg::TRICKLE_DROP);
    end
    st_d.effOut = eff;

    // host writes
    if (hostBus.wrStb) begin
      case (hostBus.addr)
        ggrb_pkg::ADDR_AVAIL_HIGH:   st_d.availCharge[15:8] = hostBus.wrData;
        ggrb_pkg::ADDR_AVAIL_LOW:    st_d.availCharge[7:0]  = hostBus.wrData;
        ggrb_pkg::ADDR_PACK_TYPE:    st_d.packTypeTag = hostBus.wrData;
        ggrb_pkg::ADDR_LEARNED_FULL: begin
          st_d.learnedFull = hostBus.wrData;
          softReset = st_q.softResetArmed && hostBus.wrData == ggrb_pkg::ZERO_BYTE;
        end
        ggrb_pkg::ADDR_OVERRIDE: begin
          st_d.overrideEnable = hostBus.wrData[ggrb_pkg::OVR_ENABLE_BIT];
          st_d.overrideBits   = hostBus.wrData[5:1];
          st_d.overrideMsb    = hostBus.wrData[ggrb_pkg::OVR_MSB_BIT];
        end
        ggrb_pkg::ADDR_OFFSET:       st_d.offsetCorr = hostBus.wrData;
        ggrb_pkg::ADDR_SELF_DIS:     st_d.selfDis    = hostBus.wrData;
        ggrb_pkg::ADDR_FILTER:       st_d.filterThr  = hostBus.wrData;
        ggrb_pkg::ADDR_LOAD_COMP:    st_d.loadComp   = hostBus.wrData;
        ggrb_pkg::ADDR_CHARGE_COMP:  st_d.chargeComp = hostBus.wrData;
        default: ;
      endcase
      // every write except a zero write to the soft-reset register clears the arming, the full-capacity write included
      st_d.softResetArmed = hostBus.addr == ggrb_pkg::ADDR_SOFT_RESET && hostBus.wrData == ggrb_pkg::ZERO_BYTE;
    end

    // host reads
    case (hostBus.addr)
      ggrb_pkg::ADDR_TEMP_GAUGE:   rdMux = {temperatureCode, gaugeNibble};
      ggrb_pkg::ADDR_AVAIL_HIGH:   rdMux = st_q.availCharge[15:8];
      ggrb_pkg::ADDR_AVAIL_LOW:    rdMux = st_q.availCharge[7:0];
      ggrb_pkg::ADDR_PACK_TYPE:    rdMux = st_q.packTypeTag;
      ggrb_pkg::ADDR_LEARNED_FULL: rdMux = st_q.learnedFull;
      ggrb_pkg::ADDR_SEC_FLAGS:    rdMux = {st_q.chargeRateFlag, 6'h00, st_q.overloadFlag};
      ggrb_pkg::ADDR_PULLDOWN:     rdMux = {2'h0, st_q.pulldownMap};
      ggrb_pkg::ADDR_PULLUP:       rdMux = {2'h0, st_q.pullupMap};
      ggrb_pkg::ADDR_OFFSET:       rdMux = st_q.offsetCorr;
      ggrb_pkg::ADDR_SELF_DIS:     rdMux = st_q.selfDis;
      ggrb_pkg::ADDR_FILTER:       rdMux = st_q.filterThr;
      ggrb_pkg::ADDR_LOAD_COMP:    rdMux = st_q.loadComp;
      ggrb_pkg::ADDR_CHARGE_COMP:  rdMux = st_q.chargeComp;
      default:                     rdMux = ggrb_pkg::ZERO_BYTE;
    endcase
    if (hostBus.rdStb) begin
      st_d.rdData  = rdMux;
      st_d.rdValid = 1'b1;
    end

    // segments: override replaces display data while enabled
    st_d.segOut = st_q.overrideEnable ? st_q.overrideBits : displaySegments;

    if (softReset) begin
      st_d.learnedFull    = programmedFullCapacity;
      st_d.validDis       = 1'b0;
      st_d.overrideEnable = 1'b0;
      st_d.loadComp       = ggrb_pkg::ZERO_BYTE;
      st_d.availCharge    = ggrb_pkg::ZERO_WORD;
      st_d.replaced       = 1'b1;
      st_d.softResetArmed = 1'b0;
      st_d.pinPhase       = 2'h0;
    end
  end

  assign hostBus.rdData = rdMux;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_q                <= '0;
      st_q.learnedFull    <= ggrb_pkg::ZERO_BYTE;
      st_q.filterThr      <= ggrb_pkg::FILTER_DEFAULT;
      st_q.replaced       <= 1'b1;
    end else if (clkEn) begin
      st_q <= st_d;
      // full capacity follows the programmed value while straps settle after reset
      if (st_q.pinPhase == 2'h1) begin
        st_q.learnedFull <= programmedFullCapacity;
      end
    end
  end

  assign rdData              = st_q.rdData;
  assign rdValid             = st_q.rdValid;
  assign segmentOutput       = st_q.segOut;
  assign chargeEfficiency    = st_q.effOut;
  assign filterThreshold     = st_q.filterThr;
  assign offsetCorrection    = st_q.offsetCorr;
  assign selfDischargeRate   = st_q.selfDis;
  assign batteryReplacedFlag = st_q.replaced;
  assign validDischargeFlag  = st_q.validDis;
endmodule : ggrb_register_bank
`default_nettype wire

/* File: ggrb_pkg.sv */
// package: register map, field positions, reset values and timing for the gauge register bank
package ggrb_pkg;
  // register offsets
  localparam logic [6:0] ADDR_TEMP_GAUGE   = 7'h02;
  localparam logic [6:0] ADDR_AVAIL_HIGH   = 7'h03;
  localparam logic [6:0] ADDR_PACK_TYPE    = 7'h04;
  localparam logic [6:0] ADDR_LEARNED_FULL = 7'h05;
  localparam logic [6:0] ADDR_SEC_FLAGS    = 7'h06;
  localparam logic [6:0] ADDR_PULLDOWN     = 7'h07;
  localparam logic [6:0] ADDR_PULLUP       = 7'h08;
  localparam logic [6:0] ADDR_OVERRIDE     = 7'h0a;
  localparam logic [6:0] ADDR_OFFSET       = 7'h0b;
  localparam logic [6:0] ADDR_SELF_DIS     = 7'h0c;
  localparam logic [6:0] ADDR_FILTER       = 7'h0d;
  localparam logic [6:0] ADDR_LOAD_COMP    = 7'h0e;
  localparam logic [6:0] ADDR_CHARGE_COMP  = 7'h0f;
  localparam logic [6:0] ADDR_AVAIL_LOW    = 7'h17;
  localparam logic [6:0] ADDR_SOFT_RESET   = 7'h1e;
  // field positions
  localparam int CHARGE_RATE_BIT   = 7;
  localparam int OVERLOAD_BIT      = 0;
  localparam int OVR_ENABLE_BIT    = 1;
  localparam int OVR_MSB_BIT       = 7;
  localparam int PIN_COUNT         = 6;
  localparam int SEG_COUNT         = 5;
  // reset and initial values
  localparam logic [7:0]  OFFSET_NONE      = 8'h00;
  localparam logic [7:0]  OFFSET_75UV      = 8'h2e;
  localparam logic [7:0]  OFFSET_150UV     = 8'h17;
  localparam logic [7:0]  FILTER_DEFAULT   = 8'hb4;
  localparam logic [7:0]  ZERO_BYTE        = 8'h00;
  localparam logic [15:0] ZERO_WORD        = 16'h0000;
  // charge efficiency scaling
  localparam logic [7:0]  TEMP_BAND_STEP   = 8'h05;
  localparam logic [7:0]  TRICKLE_DROP     = 8'h0f;
  localparam logic [3:0]  TEMP_BAND_30C    = 4'h7;
  // timing: charge-rate window of one second at 125 MHz
  localparam int          CLK_HZ           = 125_000_000;
  localparam int          RATE_WINDOW_MS   = 1000;
  localparam int          RATE_WINDOW_CYC  = CLK_HZ / 1000 * RATE_WINDOW_MS;
  localparam logic [7:0]  FAST_RATE_MIN    = 8'h02;
endpackage : ggrb_pkg

/* File: ggrb_host_if.sv */
// interface: register access strobes between the serial front end and the register bank
`timescale 1ns/1ps
`default_nettype none
interface ggrb_host_if;
  logic       wrStb;
  logic       rdStb;
  logic [6:0] addr;
  logic [7:0] wrData;
  logic [7:0] rdData;
  modport bank (input wrStb, input rdStb, input addr, input wrData, output rdData);
  modport port (output wrStb, output rdStb, output addr, output wrData, input rdData);
endinterface : ggrb_host_if
`default_nettype wire

/* File: ggrb_gauge_calc.sv */
// module: gauge nibble from available charge versus full reference
`timescale 1ns/1ps
`default_nettype none
module ggrb_gauge_calc (
  // clock
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  // operands
  input  wire logic [15:0] availCharge,
  input  wire logic [15:0] fullRef,
  // result
  output logic [3:0]       gaugeNibble
);
  typedef struct packed {
    logic [3:0] gauge;
  } ggrb_gc_state_t;
  ggrb_gc_state_t st_q, st_d;
  logic [19:0] scaled;
  always_comb begin
    st_d = st_q;
    scaled = {availCharge, 4'h0};
    if (availCharge == ggrb_pkg::ZERO_WORD || fullRef == ggrb_pkg::ZERO_WORD) begin
      st_d.gauge = 4'h0;
    end else if (availCharge >= fullRef) begin
      st_d.gauge = 4'hf;
    end else begin
      st_d.gauge = 4'((scaled / {4'h0, fullRef}));
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_q <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end
  assign gaugeNibble = st_q.gauge;
endmodule : ggrb_gauge_calc
`default_nettype wire

/* File: ggrb_port_front.sv */
// module: synchronises raw host access strobes into the bank's domain
`timescale 1ns/1ps
`default_nettype none
module ggrb_port_front (
  // clock
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  // raw request from the serial decoder
  input  wire logic       reqWr,
  input  wire logic       reqRd,
  input  wire logic [6:0] reqAddr,
  input  wire logic [7:0] reqData,
  // bank side
  ggrb_host_if.port       bus
);
  typedef struct packed {
    logic [1:0] wrSync;
    logic [1:0] rdSync;
    logic       wrSeen;
    logic       rdSeen;
  } ggrb_pf_state_t;
  ggrb_pf_state_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    // second stage only feeds the edge detect, first stage is left alone
    st_d.wrSync = {st_q.wrSync[0], reqWr};
    st_d.rdSync = {st_q.rdSync[0], reqRd};
    st_d.wrSeen = st_q.wrSync[1];
    st_d.rdSeen = st_q.rdSync[1];
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_q <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end
  // address and data are held stable by the decoder across the strobe
  assign bus.wrStb  = st_q.wrSync[1] & ~st_q.wrSeen & clkEn;
  assign bus.rdStb  = st_q.rdSync[1] & ~st_q.rdSeen & clkEn;
  assign bus.addr   = reqAddr;
  assign bus.wrData = reqData;
endmodule : ggrb_port_front
`default_nettype wire

/* File: ggrb_register_bank_chk.sv */
// checker: port-level assertions for the gauge register bank
`timescale 1ns/1ps
`default_nettype none
module ggrb_register_bank_chk (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rstn,
  // host request and answer
  input wire logic       reqWr,
  input wire logic       reqRd,
  input wire logic [7:0] rdData,
  input wire logic       rdValid,
  // measurement and display
  input wire logic       chargeTick,
  input wire logic [4:0] displaySegments,
  input wire logic [4:0] segmentOutput,
  // straps and status
  input wire logic [5:0] pinPulldown,
  input wire logic [5:0] pinPullup,
  input wire logic [7:0] filterThreshold,
  input wire logic [7:0] offsetCorrection,
  input wire logic       batteryReplacedFlag,
  input wire logic       validDischargeFlag
);
  logic       wrSeen_q;
  logic [7:0] offsetExp;
  // straps stay put in use, so the expected offset is a plain decode
  assign offsetExp = pinPulldown[5] ? ggrb_pkg::OFFSET_75UV :
                     (pinPullup[5] ? ggrb_pkg::OFFSET_150UV : ggrb_pkg::OFFSET_NONE);
  // segments are only known to follow the display until the first host write
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wrSeen_q <= 1'b0;
    end else if (reqWr) begin
      wrSeen_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  a_read_latency: assert property ($rose(reqRd) |-> ##1 !rdValid [*2] ##1 rdValid)
    else $error("read answer not three cycles after request");
  a_valid_pulse: assert property (rdValid |=> !rdValid)
    else $error("read valid longer than one cycle");
  a_valid_cause: assert property (rdValid |-> $past(reqRd, 3))
    else $error("read valid without request");
  a_rdata_hold: assert property ($changed(rdData) |-> rdValid)
    else $error("read data moved without valid");
  a_reset_state: assert property ($rose(rstn) |-> batteryReplacedFlag && !validDischargeFlag && !rdValid)
    else $error("reset state wrong");
  a_strap_load: assert property ($rose(rstn) |-> ##4 offsetCorrection == offsetExp)
    else $error("offset not loaded from strap");
  a_seg_normal: assert property (!wrSeen_q && $past(rstn) |-> segmentOutput == $past(displaySegments))
    else $error("segments not following display");
  a_brp_hold: assert property (batteryReplacedFlag && !chargeTick && !$past(chargeTick) |=> batteryReplacedFlag)
    else $error("replaced flag dropped without charge");
  a_filter_write: assert property ($changed(filterThreshold) |-> $past(reqWr, 2))
    else $error("filter threshold changed without write");
endmodule : ggrb_register_bank_chk
bind ggrb_register_bank ggrb_register_bank_chk uChk (.clk_sys(clk_sys), .rstn(rstn), .reqWr(reqWr), .reqRd(reqRd),
  .rdData(rdData), .rdValid(rdValid), .chargeTick(chargeTick), .displaySegments(displaySegments),
  .segmentOutput(segmentOutput), .pinPulldown(pinPulldown), .pinPullup(pinPullup),
  .filterThreshold(filterThreshold), .offsetCorrection(offsetCorrection),
  .batteryReplacedFlag(batteryReplacedFlag), .validDischargeFlag(validDischargeFlag));
`default_nettype wire

/* File: ggrb_host_model.sv */
// host model: drives register requests the way the serial decoder does
`timescale 1ns/1ps
`default_nettype none
module ggrb_host_model (
  // clock
  input wire logic        clk_sys,
  // request towards the bank
  output logic            reqWr,
  output logic            reqRd,
  output logic [6:0]      reqAddr,
  output logic [7:0]      reqData,
  // answer
  input wire logic [7:0]  rdData,
  input wire logic        rdValid
);
  initial begin
    reqWr = 1'b0;
    reqRd = 1'b0;
    reqAddr = 7'h7f;
    reqData = 8'h00;
  end
  // released lines show the inverse so stale values cannot pass for held ones
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reqAddr = a;
    reqData = (a == ggrb_pkg::ADDR_OVERRIDE && d[1]) ? (d | 8'h80) : d;
    reqWr = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    reqWr = 1'b0;
    reqAddr = ~reqAddr;
    reqData = ~reqData;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    int n;
    @(posedge clk_sys);
    #1;
    reqAddr = a;
    reqRd = 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rdValid !== 1'b1 && n < 8);
    d = (rdValid === 1'b1) ? rdData : 8'hxx;
    #1;
    reqRd = 1'b0;
    reqAddr = ~reqAddr;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : rd
  task automatic soft_reset();
    wr(ggrb_pkg::ADDR_SOFT_RESET, 8'h00);
    wr(ggrb_pkg::ADDR_LEARNED_FULL, 8'h00);
  endtask : soft_reset
endmodule : ggrb_host_model
`default_nettype wire

/* File: tb_gas_gauge_register_bank.sv */
// testbench: register bank driven through the host model
`timescale 1ns/1ps
`default_nettype none
module tb_gas_gauge_register_bank;
  logic       clk_sys, rstn, reqWr, reqRd, rdValid, chargeTick, dischargeTick, selfDischargeTick;
  logic       belowOverloadThresh, batteryReplacedFlag, validDischargeFlag;
  logic [6:0] reqAddr;
  logic [7:0] reqData, rdData, programmedFullCapacity, chargeEfficiency, filterThreshold;
  logic [7:0] offsetCorrection, selfDischargeRate;
  logic [3:0] temperatureCode;
  logic [5:0] pinPulldown, pinPullup;
  logic [4:0] displaySegments, segmentOutput;
  logic [6:0] rstAddr [13];
  logic [7:0] rstExp [13];
  int         n_errors, checked, cycles;

  ggrb_register_bank uut (.clk_sys(clk_sys), .rstn(rstn), .clkEn(1'b1), .reqWr(reqWr), .reqRd(reqRd),
    .reqAddr(reqAddr), .reqData(reqData), .rdData(rdData), .rdValid(rdValid), .chargeTick(chargeTick),
    .dischargeTick(dischargeTick), .selfDischargeTick(selfDischargeTick), .loadCompTick(1'b0),
    .belowChargeThresh(1'b0), .belowOverloadThresh(belowOverloadThresh), .atEmpty(1'b0),
    .temperatureCode(temperatureCode), .pinPulldown(pinPulldown), .pinPullup(pinPullup),
    .programmedFullCapacity(programmedFullCapacity), .displaySegments(displaySegments),
    .segmentOutput(segmentOutput), .chargeEfficiency(chargeEfficiency), .filterThreshold(filterThreshold),
    .offsetCorrection(offsetCorrection), .selfDischargeRate(selfDischargeRate),
    .batteryReplacedFlag(batteryReplacedFlag), .validDischargeFlag(validDischargeFlag));
  ggrb_host_model host (.clk_sys(clk_sys), .reqWr(reqWr), .reqRd(reqRd), .reqAddr(reqAddr),
    .reqData(reqData), .rdData(rdData), .rdValid(rdValid));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // whole run is well under two thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      tally_and_finish();
    end
  end
  task automatic chkv(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chkv
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chkv(d, exp, "register read");
  endtask : rdchk
  task automatic pulse(ref logic t, input int n);
    repeat (n) begin
      t = 1'b1;
      @(posedge clk_sys);
      #1;
      t = 1'b0;
      @(posedge clk_sys);
      #1;
    end
  endtask : pulse
  task automatic chk_seg_normal();
    chkv({3'b000, segmentOutput}, {3'b000, displaySegments}, "segments normal");
  endtask : chk_seg_normal

  initial begin
    {rstn, chargeTick, dischargeTick, selfDischargeTick, belowOverloadThresh} = 5'b0_0000;
    {n_errors, checked, cycles} = '0;
    temperatureCode = 4'h6;
    pinPulldown = 6'b00_1001;
    pinPullup = 6'b11_0100;
    programmedFullCapacity = 8'h40;
    displaySegments = 5'b0_1010;
    rstAddr = '{7'h07, 7'h08, 7'h0b, 7'h0d, 7'h03, 7'h17, 7'h0e, 7'h05, 7'h06, 7'h0a, 7'h10, 7'h1e, 7'h02};
    rstExp = '{8'h09, 8'h34, 8'h17, 8'hb4, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h60};
    repeat (12) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    for (int i = 0; i < 13; i++) begin
      rdchk(rstAddr[i], rstExp[i]);
    end
    chkv(chargeEfficiency, 8'h4b, "trickle efficiency");
    chkv(selfDischargeRate, 8'hfc, "self-discharge strap");
    displaySegments = 5'b1_0101;
    rdchk(ggrb_pkg::ADDR_SEC_FLAGS, 8'h00);
    chk_seg_normal();
    $display("test reset values done");
    host.wr(ggrb_pkg::ADDR_PACK_TYPE, 8'ha5);
    rdchk(ggrb_pkg::ADDR_PACK_TYPE, 8'ha5);
    host.wr(ggrb_pkg::ADDR_FILTER, 8'h5a);
    rdchk(ggrb_pkg::ADDR_FILTER, 8'h5a);
    chkv(filterThreshold, 8'h5a, "filter port");
    host.wr(ggrb_pkg::ADDR_PULLDOWN, 8'hff);
    rdchk(ggrb_pkg::ADDR_PULLDOWN, 8'h09);
    belowOverloadThresh = 1'b1;
    rdchk(ggrb_pkg::ADDR_SEC_FLAGS, 8'h01);
    belowOverloadThresh = 1'b0;
    rdchk(ggrb_pkg::ADDR_SEC_FLAGS, 8'h00);
    $display("test host registers done");
    pulse(chargeTick, 5);
    rdchk(ggrb_pkg::ADDR_AVAIL_LOW, 8'h05);
    rdchk(ggrb_pkg::ADDR_SEC_FLAGS, 8'h80);
    pulse(dischargeTick, 2);
    pulse(selfDischargeTick, 1);
    rdchk(ggrb_pkg::ADDR_AVAIL_LOW, 8'h02);
    host.wr(ggrb_pkg::ADDR_LEARNED_FULL, 8'h10);
    rdchk(ggrb_pkg::ADDR_LEARNED_FULL, 8'h10);
    host.wr(ggrb_pkg::ADDR_AVAIL_HIGH, 8'h07);
    host.wr(ggrb_pkg::ADDR_AVAIL_LOW, 8'hff);
    rdchk(ggrb_pkg::ADDR_TEMP_GAUGE, 8'h67);
    host.wr(ggrb_pkg::ADDR_AVAIL_HIGH, 8'h10);
    rdchk(ggrb_pkg::ADDR_TEMP_GAUGE, 8'h6f);
    host.wr(ggrb_pkg::ADDR_AVAIL_HIGH, 8'hff);
    pulse(chargeTick, 1);
    rdchk(ggrb_pkg::ADDR_AVAIL_HIGH, 8'hff);
    temperatureCode = 4'hc;
    rdchk(ggrb_pkg::ADDR_TEMP_GAUGE, 8'hcf);
    chkv(chargeEfficiency, 8'h41, "hot fast efficiency");
    $display("test counter and gauge done");
    host.wr(ggrb_pkg::ADDR_OVERRIDE, 8'h36);
    chkv({3'b000, segmentOutput}, 8'h1b, "segments overridden");
    host.wr(ggrb_pkg::ADDR_OVERRIDE, 8'h00);
    chk_seg_normal();
    host.wr(ggrb_pkg::ADDR_OVERRIDE, 8'h3e);
    rstn = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    displaySegments = 5'b0_0110;
    rdchk(ggrb_pkg::ADDR_AVAIL_HIGH, 8'h00);
    chk_seg_normal();
    $display("test override done");
    host.wr(ggrb_pkg::ADDR_LOAD_COMP, 8'h33);
    rdchk(ggrb_pkg::ADDR_LOAD_COMP, 8'h33);
    pulse(chargeTick, 3);
    host.wr(ggrb_pkg::ADDR_OVERRIDE, 8'h3e);
    host.soft_reset();
    chk_seg_normal();
    chkv({7'h00, batteryReplacedFlag}, 8'h01, "replaced flag");
    chkv({7'h00, validDischargeFlag}, 8'h00, "valid discharge flag");
    rdchk(ggrb_pkg::ADDR_LEARNED_FULL, 8'h40);
    rdchk(ggrb_pkg::ADDR_AVAIL_LOW, 8'h00);
    rdchk(ggrb_pkg::ADDR_LOAD_COMP, 8'h00);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule : tb_gas_gauge_register_bank
`default_nettype wire
